// file: rtl/rotate_instruction_unit.sv
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Behaviour
// - Left via carry: bits shift up, write back
// - Memory variant: carry gets old bit 7
// - Old carry enters result bit 0
// - Accumulator variant: memory left unmodified
// - Accumulator gets shifted bits, carry bit 7
// - Right rotate: bit 0 to 7, write back
// - Right rotate changes no status flag
module rotate_instruction_unit
    import rotate_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        rstn_in,
    // Instruction request
    input  wire rot_req_type req_in,
    // Data memory read path, operand valid with the request
    input  wire logic [7:0]  mem_rdata_in,
    output logic [ADDR_W-1:0] mem_raddr_out,
    // Status register in and out
    input  wire logic [7:0]  status_in,
    output logic [7:0]       status_out,
    output logic             status_we_out,
    // Memory write-back
    output mem_wr_type       mem_wr_out,
    // Accumulator
    output logic [7:0]       acc_out,
    output logic             acc_we_out,
    // Completion
    output logic             done_out
);

    // Decoded operation and the core's answer
    rot_op_type  op_sel;
    rot_res_type res;

    // Write-back registers and next values
    logic              mem_we_r;
    logic              mem_we_nxt;
    logic [ADDR_W-1:0] mem_addr_r;
    logic [ADDR_W-1:0] mem_addr_nxt;
    logic [7:0]        mem_data_r;
    logic [7:0]        mem_data_nxt;

    // Accumulator registers and next values
    logic [7:0]        acc_r;
    logic [7:0]        acc_nxt;
    logic              acc_we_r;
    logic              acc_we_nxt;

    // Status registers and next values
    logic [7:0]        status_r;
    logic [7:0]        status_nxt;
    logic              status_we_r;
    logic              status_we_nxt;

    // Completion register and next value
    logic              done_r;
    logic              done_nxt;

    // Operation to run now, idle while no request stands
    function automatic rot_op_type accepted_op(input rot_req_type req);
        rot_op_type op;
        op = OP_NONE;
        if (req.valid) begin
            op = req.op;
        end
        return op;
    endfunction

    // Whether an operation does any work at all
    function automatic logic is_busy(input rot_op_type op);
        return op != OP_NONE;
    endfunction

    // Status byte with only the carry position replaced
    function automatic logic [7:0] with_carry(input logic [7:0] flags,
                                              input logic       carry);
        logic [7:0] merged;
        merged            = flags;
        merged[CARRY_POS] = carry;
        return merged;
    endfunction

    // Operand address follows the request in the same cycle
    assign mem_raddr_out = req_in.addr;
    assign op_sel        = accepted_op(req_in);

    // Rotate network, purely combinational
    rotate_core u_core (
        .op_in      (op_sel),
        .operand_in (mem_rdata_in),
        .carry_in   (status_in[CARRY_POS]),
        .res_out    (res)
    );

    // Write-back goes to the location the operand came from
    always_comb begin
        mem_we_nxt   = res.to_mem;
        mem_addr_nxt = req_in.addr;
        mem_data_nxt = DATA_RESET;          // Idle write-back data reads zero
        if (res.to_mem) begin
            mem_data_nxt = res.data;
        end
    end

    // Write-back strobe, one cycle after the request
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mem_we_r <= 1'b0;
        end else begin
            mem_we_r <= mem_we_nxt;
        end
    end

    // Write-back address
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mem_addr_r <= '0;
        end else begin
            mem_addr_r <= mem_addr_nxt;
        end
    end

    // Write-back data
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mem_data_r <= DATA_RESET;
        end else begin
            mem_data_r <= mem_data_nxt;
        end
    end

    // Accumulator holds unless the accumulator variant runs
    always_comb begin
        acc_we_nxt = res.to_acc;
        acc_nxt    = acc_r;
        if (res.to_acc) begin
            acc_nxt = res.data;
        end
    end

    // Accumulator value
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acc_r <= ACC_RESET;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // Accumulator write strobe
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acc_we_r <= 1'b0;
        end else begin
            acc_we_r <= acc_we_nxt;
        end
    end

    // Status: carry may change, all other flags pass through
    always_comb begin
        status_we_nxt = res.carry_upd;
        status_nxt    = status_in;
        if (res.carry_upd) begin
            status_nxt = with_carry(status_in, res.carry);
        end
    end

    // Status value
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            status_r <= DATA_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    // Status write strobe
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            status_we_r <= 1'b0;
        end else begin
            status_we_r <= status_we_nxt;
        end
    end

    // Completion follows any accepted operation
    always_comb begin
        done_nxt = is_busy(op_sel);
    end

    // Completion strobe
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            done_r <= 1'b0;
        end else begin
            done_r <= done_nxt;
        end
    end

    // Write-back bundle from its flip-flops
    always_comb begin
        mem_wr_out.we   = mem_we_r;
        mem_wr_out.addr = mem_addr_r;
        mem_wr_out.data = mem_data_r;
    end

    // Remaining outputs straight from flip-flops
    assign acc_out       = acc_r;
    assign acc_we_out    = acc_we_r;
    assign status_out    = status_r;
    assign status_we_out = status_we_r;
    assign done_out      = done_r;

endmodule

// file: include/rotate_pkg.sv
package rotate_pkg;

    // Status register bit positions
    localparam int CARRY_POS       = 0;
    localparam int AUX_CARRY_POS   = 1;
    localparam int ZERO_POS        = 2;
    localparam int OVERFLOW_POS    = 3;
    localparam int POWER_DOWN_POS  = 4;
    localparam int TIMEOUT_POS     = 5;
    localparam int TIMER_ONE_POS   = 6;
    localparam int TIMER_TWO_POS   = 7;

    // Widths and reset values
    localparam int          ADDR_W      = 7;
    localparam logic [7:0]  ACC_RESET   = 8'h00;
    localparam logic [7:0]  DATA_RESET  = 8'h00;

    // Rotate operations
    typedef enum logic [1:0] {
        OP_NONE,
        OP_ROT_LEFT_MEM,
        OP_ROT_LEFT_ACC,
        OP_ROT_RIGHT
    } rot_op_type;

    // Request from the decoder
    typedef struct packed {
        logic              valid;
        rot_op_type        op;
        logic [ADDR_W-1:0] addr;
    } rot_req_type;

    // Memory write-back
    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } mem_wr_type;

    // Result of the rotate logic
    typedef struct packed {
        logic [7:0] data;
        logic       carry;
        logic       carry_upd;
        logic       to_mem;
        logic       to_acc;
    } rot_res_type;

endpackage

// file: rtl/rotate_core.sv
`timescale 1ns/1ps
// Combinational rotate network
module rotate_core
    import rotate_pkg::*;
(
    // Operation and operands
    input  wire rot_op_type  op_in,
    input  wire logic [7:0]  operand_in,
    input  wire logic        carry_in,
    // Result
    output rot_res_type      res_out
);

    // Select the rotation and its side effects
    always_comb begin
        res_out = '0;
        unique case (op_in)
            OP_ROT_LEFT_MEM: begin
                res_out.data      = {operand_in[6:0], carry_in};
                res_out.carry     = operand_in[7];
                res_out.carry_upd = 1'b1;
                res_out.to_mem    = 1'b1;
            end
            OP_ROT_LEFT_ACC: begin
                res_out.data      = {operand_in[6:0], carry_in};
                res_out.carry     = operand_in[7];
                res_out.carry_upd = 1'b1;
                res_out.to_acc    = 1'b1;
            end
            OP_ROT_RIGHT: begin
                res_out.data      = {operand_in[0], operand_in[7:1]};
                res_out.carry     = carry_in;
                res_out.to_mem    = 1'b1;
            end
            OP_NONE: begin
                res_out.carry     = carry_in;
            end
        endcase
    end

endmodule

// file: verification/mem_status_model.sv
`timescale 1ns/1ps
// Data memory and status register on the far side of the unit
module mem_status_model
    import rotate_pkg::*;
(
    // Unit side
    input  wire logic [ADDR_W-1:0] raddr_in,
    input  wire mem_wr_type        wr_in,
    input  wire logic [7:0]        st_in,
    input  wire logic              st_we_in,
    input  wire logic              clock_in,
    // Bench preset of one byte and the flags
    input  wire logic              preset_in,
    input  wire logic [ADDR_W-1:0] preset_addr_in,
    input  wire logic [7:0]        preset_data_in,
    input  wire logic [7:0]        preset_st_in,
    // Operand and flags
    output logic [7:0]             rdata_out,
    output logic [7:0]             st_out
);
    logic [7:0] mem [128];
    // Operand is ready in the request cycle
    assign rdata_out = mem[raddr_in];
    // Write-back and flag update, a preset wins
    always @(posedge clock_in) begin
        if (wr_in.we) mem[wr_in.addr] <= wr_in.data;
        if (st_we_in) st_out <= st_in;
        if (preset_in) begin
            mem[preset_addr_in] <= preset_data_in;
            st_out <= preset_st_in;
        end
    end
endmodule

// file: verification/rot_chk_sva.sv
`timescale 1ns/1ps
// Port checks for the rotate unit
module rot_chk
    import rotate_pkg::*;
(
    // Unit ports
    input wire logic        clock_in,
    input wire logic        rstn_in,
    input wire rot_req_type req_in,
    input wire logic [7:0]  mem_rdata_in,
    input wire logic [7:0]  status_in,
    input wire logic [7:0]  status_out,
    input wire logic        status_we_out,
    input wire mem_wr_type  mem_wr_out,
    input wire logic [7:0]  acc_out,
    input wire logic        acc_we_out
);
    wire logic [7:0] d = mem_rdata_in;
    wire logic       c = status_in[CARRY_POS];
    wire mem_wr_type w = mem_wr_out;
    wire logic       cf = status_out[CARRY_POS];
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    // Accepted request of each kind
    sequence s_lm; req_in.valid && req_in.op == OP_ROT_LEFT_MEM; endsequence
    sequence s_la; req_in.valid && req_in.op == OP_ROT_LEFT_ACC; endsequence
    sequence s_rr; req_in.valid && req_in.op == OP_ROT_RIGHT; endsequence
    chk_lm_shift: assert property (s_lm |=> w.we && w.data[7:1] == $past(d[6:0]))
        else $error("shift");
    chk_lm_addr: assert property (s_lm |=> w.addr == $past(req_in.addr))
        else $error("write-back address");
    chk_lm_carry: assert property (s_lm |=> status_we_out && status_out[0] == $past(d[7]))
        else $error("carry");
    chk_old_carry: assert property (s_lm |=> w.data[0] == $past(c))
        else $error("old carry");
    chk_acc_nowrite: assert property (s_la |=> acc_we_out && !w.we)
        else $error("acc write");
    chk_acc_carry: assert property (s_la |=> status_we_out && cf == $past(d[7]))
        else $error("acc carry");
    chk_acc_value: assert property (s_la |=> acc_out == {$past(d[6:0]), $past(c)})
        else $error("acc value");
    chk_rr_data: assert property (s_rr |=> w.we && w.data == {$past(d[0]), $past(d[7:1])})
        else $error("right data");
    chk_rr_flags: assert property (s_rr |=> !status_we_out)
        else $error("right flags");
    chk_carry_only: assert property (status_we_out |-> status_out[7:1] == $past(status_in[7:1]))
        else $error("other flags");
endmodule
bind rotate_instruction_unit rot_chk chk_u (.clock_in, .rstn_in, .req_in, .mem_rdata_in,
    .status_in, .status_out, .status_we_out, .mem_wr_out, .acc_out, .acc_we_out);

// file: verification/rotate_instruction_unit_tb_top.sv
`timescale 1ns/1ps
// Bench for the rotate unit
module rotate_instruction_unit_tb_top
    import rotate_pkg::*;
;
    logic              pre = 0;
    logic [ADDR_W-1:0] pre_a = '0;
    logic [7:0]        pre_d = '0;
    logic [7:0]        pre_s = '0;
    logic [7:0]        acc_exp = ACC_RESET;
    logic              clock_in = 0;
    logic              rstn_in = 0;
    rot_req_type       req_in = '0;
    logic [ADDR_W-1:0] ra;
    logic [7:0]        rd, st, so, acc;
    logic              swe, awe, done;
    mem_wr_type        wr;
    int                failures = 0;
    int                n_tests = 0;
    always #50 clock_in = ~clock_in;
    rotate_instruction_unit dut_u (.clock_in, .rstn_in, .req_in, .mem_rdata_in(rd),
        .mem_raddr_out(ra), .status_in(st), .status_out(so), .status_we_out(swe),
        .mem_wr_out(wr), .acc_out(acc), .acc_we_out(awe), .done_out(done));
    mem_status_model p_u (.clock_in, .raddr_in(ra), .wr_in(wr), .st_in(so),
        .st_we_in(swe), .preset_in(pre), .preset_addr_in(pre_a), .preset_data_in(pre_d),
        .preset_st_in(pre_s), .rdata_out(rd), .st_out(st));
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // Preset operand and flags, request once, check the answer and then the memory
    task automatic run(input rot_op_type op, input logic [ADDR_W-1:0] a,
                       input logic [7:0] d, input logic [7:0] s);
        logic [7:0] res;
        logic [7:0] fl;
        logic [7:0] mem_exp;
        logic [3:0] en;
        res           = {d[6:0], s[CARRY_POS]};
        fl            = s;
        fl[CARRY_POS] = d[7];
        mem_exp       = res;
        en            = 4'b1101;
        if (op == OP_ROT_LEFT_ACC) begin
            mem_exp = d;
            en      = 4'b1011;
            acc_exp = res;
        end
        if (op == OP_ROT_RIGHT) begin
            res     = {d[0], d[7:1]};
            fl      = s;
            mem_exp = res;
            en      = 4'b1100;
        end
        @(posedge clock_in);
        req_in <= '0;
        pre    <= 1'b1;
        pre_a  <= a;
        pre_d  <= d;
        pre_s  <= s;
        @(posedge clock_in);
        pre    <= 1'b0;
        req_in <= '{1'b1, op, a};
        @(posedge clock_in);
        req_in <= '{1'b0, OP_NONE, a};
        @(negedge clock_in);
        check({4'h0, done, wr.we, awe, swe}, {4'h0, en});
        check(wr.data, en[2] ? res : DATA_RESET);
        check({1'b0, wr.addr}, {1'b0, a});
        check(acc, acc_exp);
        if (op != OP_ROT_RIGHT)
            check(so, fl);
        @(negedge clock_in);
        check(rd, mem_exp);
        check(st, fl);
        check({4'h0, done, wr.we, awe, swe}, 8'h00);
    endtask
    // Verdict
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Reset, then every rotate kind over varied operands and flags
    initial begin
        repeat (20) @(posedge clock_in);
        rstn_in <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            run(rot_op_type'(i % 3 + 1), 7'(i), 8'(8'h96 ^ i * 8'h4d), 8'(i * 8'h65));
            $display("test %0d done", i);
        end
        complete_run();
    end
endmodule
